// [distance_edge_params.svh]
`ifndef DISTANCE_EDGE_PARAMS_SVH
`define DISTANCE_EDGE_PARAMS_SVH
// Notes on behaviour
// R01 - Evaluate distances only inside near/far window.
// R02 - Application allows 15 mm band beyond limits; the code evaluates only from the near limit to the far limit, with no band.
// R03 - Round entered limits to whole millimetres.
// R04 - Limits default to physical range, 200-1000 mm.
// R05 - Assigned switching output goes active on change.
// R06 - Change qualifies between configured minimum and maximum.
// R07 - Only sample difference matters, not absolute distance.
// R08 - Hysteresis separates switch-on and switch-off thresholds.
// R09 - Direction selects both, positive or negative changes.
// R10 - Compare with sample 1 to 256 cycles back.
// R11 - Operator should prefer fixed cycle time here.
// R12 - One measurement per cycle-time interval.
// R13 - Auto mode adapts rate to stable measurement.
// R14 - Signal level below limit makes measurement impossible.
// R15 - Report relative distance with offset, absolute too.
// R16 - Analog value shown only while analog enabled.
// R17 - Window and edge settings need advanced level.
// R18 - Keep 256-sample history, update once per cycle.

// Distances are signed, in steps of 0.1 mm.
`define DIST_W        20
`define MM_STEPS      10
`define PHYS_NEAR     20'h007D0
`define PHYS_FAR      20'h02710
`define CHG_LIMIT     99999
`define HYST_LIMIT    1000
`define MIN_CHG_RST   20'h00064
`define MAX_CHG_RST   20'h003E8
`define HYST_RST      20'h00005
`define LAG_RST       9'h008
`define LAG_MAX       256
`define OFFSET_RST    20'hE8900
`define LEVEL_LIM_RST 16'h0100

`define MCLK_NS 8
`define CT0_US  300
`define CT1_US  500
`define CT2_US  1000
`define CT3_US  5000
`define CT4_US  10000
`define SEL_MAX 3'h4

`define OFS_CTRL    8'h00
`define OFS_NEAR    8'h04
`define OFS_FAR     8'h08
`define OFS_MINCHG  8'h0C
`define OFS_MAXCHG  8'h10
`define OFS_HYST    8'h14
`define OFS_LAG     8'h18
`define OFS_EDGECFG 8'h1C
`define OFS_OFFSET  8'h20
`define OFS_LVLLIM  8'h24
`define OFS_STATUS  8'h28
`define OFS_REL     8'h2C
`define OFS_ABS     8'h30
`define OFS_ANALOG  8'h34
`define OFS_LEVEL   8'h38
`endif

// [distance_edge_pkg.sv]
package distance_edge_pkg;
  typedef enum logic [1:0] {
    DIR_BOTH = 2'b00,
    DIR_POS  = 2'b01,
    DIR_NEG  = 2'b10
  } dir_e;
endpackage

// [history_buffer.sv]
`timescale 1ns/1ps
module history_buffer #(
  parameter int DEPTH = 256,
  parameter int W     = 20,
  parameter int AW    = 8
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          push,
  input  wire logic [W-1:0]  din,
  input  wire logic [AW:0]   lag,
  output logic      [W-1:0]  dout,
  output logic      [AW:0]   fill
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW:0]   fill_r;
  wire  [AW-1:0] rdIdx = wptr_r - lag[AW-1:0];

  // A lag of the full depth wraps onto the write slot, which holds the oldest entry.
  assign dout = mem[rdIdx];
  assign fill = fill_r;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr_r] <= din;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wptr_r <= '0;
      fill_r <= '0;
    end else if (push) begin
      wptr_r <= wptr_r + 1'b1;
      if (fill_r != (AW+1)'(DEPTH)) begin
        fill_r <= fill_r + 1'b1;
      end
    end
  end
endmodule

// [cycle_timer.sv]
`timescale 1ns/1ps
`include "distance_edge_params.svh"
module cycle_timer #(
  parameter int unsigned CYC0 = 37500,
  parameter int unsigned CYC1 = 62500,
  parameter int unsigned CYC2 = 125000,
  parameter int unsigned CYC3 = 625000,
  parameter int unsigned CYC4 = 1250000,
  parameter int          CW   = 21
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       autoMode,
  input  wire logic [2:0] fixSel,
  input  wire logic       adapt,
  input  wire logic       levelLow,
  input  wire logic       levelHigh,
  output logic            tick,
  output logic      [2:0] curSel
);
  logic [CW-1:0] cnt_r;
  logic [2:0]    autoSel_r;

  function automatic logic [CW-1:0] periodOf(input logic [2:0] s);
    case (s)
      3'h0:    periodOf = CW'(CYC0 - 1);
      3'h1:    periodOf = CW'(CYC1 - 1);
      3'h2:    periodOf = CW'(CYC2 - 1);
      3'h3:    periodOf = CW'(CYC3 - 1);
      default: periodOf = CW'(CYC4 - 1);
    endcase
  endfunction

  assign curSel = autoMode ? autoSel_r : fixSel;
  assign tick   = (cnt_r == '0); // [R12]

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= periodOf(curSel);
    end else begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // A weak return slows the rate to gain light; a strong one speeds it up again.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      autoSel_r <= 3'h0;
    end else if (adapt && levelLow && autoSel_r < `SEL_MAX) begin
      autoSel_r <= autoSel_r + 1'b1; // [R13] [R14]
    end else if (adapt && levelHigh && autoSel_r != 3'h0) begin
      autoSel_r <= autoSel_r - 1'b1; // [R13]
    end
  end
endmodule

// [distance_edge_change_eval.sv]
`timescale 1ns/1ps
`include "distance_edge_params.svh"
module distance_edge_change_eval #(
  parameter int unsigned CYC_T0 = (`CT0_US * 1000) / `MCLK_NS,
  parameter int unsigned CYC_T1 = (`CT1_US * 1000) / `MCLK_NS,
  parameter int unsigned CYC_T2 = (`CT2_US * 1000) / `MCLK_NS,
  parameter int unsigned CYC_T3 = (`CT3_US * 1000) / `MCLK_NS,
  parameter int unsigned CYC_T4 = (`CT4_US * 1000) / `MCLK_NS,
  parameter int          DEPTH  = `LAG_MAX
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wrData,
  input  wire logic               wrEn,
  input  wire logic               rdEn,
  output logic      [31:0]        rdData,
  input  wire logic [`DIST_W-1:0] distIn,
  input  wire logic [15:0]        levelIn,
  output logic                    measTrig,
  output logic                    switchOut,
  output logic      [`DIST_W-1:0] relDist,
  output logic      [`DIST_W-1:0] absDist,
  output logic      [`DIST_W-1:0] analogOut
);
  localparam int W  = `DIST_W;
  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [W-1:0] roundMm(input logic [31:0] v);
    int unsigned x;
    x = v[W-2:0];
    roundMm = W'(((x + `MM_STEPS / 2) / `MM_STEPS) * `MM_STEPS);
  endfunction

  function automatic logic [W-1:0] clampTo(input logic [31:0] v, input int lo, input int hi);
    int s;
    s = signed'(v);
    if (s > hi) begin
      s = hi;
    end else if (s < lo) begin
      s = lo;
    end
    clampTo = W'(s);
  endfunction

  function automatic logic signed [W:0] ext(input logic [W-1:0] v);
    ext = {v[W-1], v};
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic                      advanced_r;
  logic                      autoCycle_r;
  logic [2:0]                fixSel_r;
  logic                      edgeSel_r;
  logic                      analogEn_r;
  distance_edge_pkg::dir_e   dir_r;
  logic [W-1:0]              nearLim_r;
  logic [W-1:0]              farLim_r;
  logic [W-1:0]              minChg_r;
  logic [W-1:0]              maxChg_r;
  logic [W-1:0]              hyst_r;
  logic [AW:0]               lag_r;
  logic [W-1:0]              offset_r;
  logic [15:0]               levelLim_r;
  logic [31:0]               rdData_r;

  wire wrCtrl = wrEn && addr == `OFS_CTRL;
  wire wrOfs  = wrEn && addr == `OFS_OFFSET;
  wire wrLvl  = wrEn && addr == `OFS_LVLLIM;
  // Hidden settings ignore writes and read as zero at the easy level.
  wire wrAdv  = wrEn && advanced_r; // [R17]
  wire wrNear = wrAdv && addr == `OFS_NEAR;
  wire wrFar  = wrAdv && addr == `OFS_FAR;
  wire wrMin  = wrAdv && addr == `OFS_MINCHG;
  wire wrMax  = wrAdv && addr == `OFS_MAXCHG;
  wire wrHyst = wrAdv && addr == `OFS_HYST;
  wire wrLag  = wrAdv && addr == `OFS_LAG;
  wire wrDir  = wrAdv && addr == `OFS_EDGECFG;

  wire [AW:0] lagIn = (wrData == 32'h0) ? (AW+1)'(1) :
                      (wrData > 32'(DEPTH)) ? (AW+1)'(DEPTH) : wrData[AW:0];
  wire [1:0]  dirIn = (wrData[1:0] == 2'b11) ? 2'b00 : wrData[1:0];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      advanced_r  <= 1'b0; // [R17]
      autoCycle_r <= 1'b1;
      fixSel_r    <= 3'h0;
      edgeSel_r   <= 1'b0;
      analogEn_r  <= 1'b0;
    end else if (wrCtrl) begin
      advanced_r  <= wrData[0];
      autoCycle_r <= wrData[1];
      fixSel_r    <= (wrData[4:2] > `SEL_MAX) ? `SEL_MAX : wrData[4:2];
      edgeSel_r   <= wrData[5];
      analogEn_r  <= wrData[6];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      nearLim_r <= `PHYS_NEAR; // [R04]
      farLim_r  <= `PHYS_FAR;  // [R04]
    end else begin
      if (wrNear) begin
        nearLim_r <= roundMm(wrData); // [R03]
      end
      if (wrFar) begin
        farLim_r <= roundMm(wrData); // [R03]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      minChg_r <= `MIN_CHG_RST;
      maxChg_r <= `MAX_CHG_RST;
      hyst_r   <= `HYST_RST;
      lag_r    <= `LAG_RST;
      dir_r    <= distance_edge_pkg::DIR_BOTH;
    end else begin
      if (wrMin) begin
        minChg_r <= clampTo(wrData, -`CHG_LIMIT, `CHG_LIMIT); // [R06]
      end
      if (wrMax) begin
        maxChg_r <= clampTo(wrData, -`CHG_LIMIT, `CHG_LIMIT); // [R06]
      end
      if (wrHyst) begin
        hyst_r <= clampTo(wrData, 0, `HYST_LIMIT); // [R08]
      end
      if (wrLag) begin
        lag_r <= lagIn; // [R10]
      end
      if (wrDir) begin
        dir_r <= distance_edge_pkg::dir_e'(dirIn); // [R09]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      offset_r   <= `OFFSET_RST;
      levelLim_r <= `LEVEL_LIM_RST;
    end else begin
      if (wrOfs) begin
        offset_r <= wrData[W-1:0];
      end
      if (wrLvl) begin
        levelLim_r <= wrData[15:0];
      end
    end
  end

  // ****************************************************************
  // Measurement cycle and sampling
  // ****************************************************************
  logic         tick;
  logic [2:0]   curSel;
  logic         measTrig_r;
  logic         smpV_r;
  logic [W-1:0] absD_r;
  logic [15:0]  lvl_r;

  wire levelLow  = lvl_r < levelLim_r;
  wire levelHigh = {1'b0, lvl_r} >= {levelLim_r, 1'b0};

  cycle_timer #(
    .CYC0 (CYC_T0),
    .CYC1 (CYC_T1),
    .CYC2 (CYC_T2),
    .CYC3 (CYC_T3),
    .CYC4 (CYC_T4),
    .CW   (21)
  ) u_timer (
    .mclk      (mclk),
    .rstn      (rstn),
    .autoMode  (autoCycle_r),
    .fixSel    (fixSel_r),
    .adapt     (smpV_r),
    .levelLow  (levelLow),
    .levelHigh (levelHigh),
    .tick      (tick),
    .curSel    (curSel)
  );

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      measTrig_r <= 1'b0;
      smpV_r     <= 1'b0;
      absD_r     <= '0;
      lvl_r      <= '0;
    end else begin
      measTrig_r <= tick; // [R12]
      smpV_r     <= measTrig_r;
      if (measTrig_r) begin
        absD_r <= distIn;
        lvl_r  <= levelIn;
      end
    end
  end

  // ****************************************************************
  // Window and edge-change evaluation
  // ****************************************************************
  logic         edgeState_r;
  logic         inWin_r;
  logic         noMeas_r;
  logic [W-1:0] relDist_r;
  logic [W-1:0] analogOut_r;
  logic         switchOut_r;
  logic [W-1:0] histOut;
  logic [AW:0]  histFill;

  wire               inWin   = absD_r >= nearLim_r && absD_r <= farLim_r; // [R01]
  wire               sampOk  = inWin && !levelLow; // [R01] [R14]
  wire               push    = smpV_r && sampOk; // [R18]
  wire [W-1:0]       relNow  = absD_r + offset_r; // [R15]
  wire               enough  = histFill >= lag_r;
  // Only the step between the two samples counts, wherever the object sits.
  wire signed [W:0]  diff    = ext(relNow) - ext(histOut); // [R07]
  wire signed [W:0]  mag     = diff[W] ? -diff : diff;
  wire signed [W:0]  hystAdd = edgeState_r ? ext(hyst_r) : '0;
  wire signed [W:0]  loBound = ext(minChg_r) - hystAdd; // [R08]
  wire signed [W:0]  hiBound = ext(maxChg_r) + hystAdd; // [R08]
  wire               dirOk   = (dir_r == distance_edge_pkg::DIR_BOTH) ||
                               (dir_r == distance_edge_pkg::DIR_POS && diff > 0) ||
                               (dir_r == distance_edge_pkg::DIR_NEG && diff < 0); // [R09]
  wire               hit     = enough && dirOk && mag >= loBound && mag <= hiBound; // [R06]
  wire               edgeNxt = sampOk ? hit : edgeState_r;

  history_buffer #(
    .DEPTH (DEPTH),
    .W     (W),
    .AW    (AW)
  ) u_hist (
    .mclk (mclk),
    .rstn (rstn),
    .push (push),
    .din  (relNow),
    .lag  (lag_r), // [R10]
    .dout (histOut),
    .fill (histFill)
  );

  // A blanked or impossible sample leaves the output where it was.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      edgeState_r <= 1'b0;
      switchOut_r <= 1'b0;
      inWin_r     <= 1'b0;
      noMeas_r    <= 1'b0;
      relDist_r   <= '0;
      analogOut_r <= '0;
    end else if (smpV_r) begin
      edgeState_r <= edgeNxt; // [R18]
      switchOut_r <= edgeSel_r && edgeNxt; // [R05]
      inWin_r     <= inWin;
      noMeas_r    <= levelLow; // [R14]
      relDist_r   <= relNow; // [R15]
      analogOut_r <= analogEn_r ? absD_r - nearLim_r : '0; // [R16]
    end else if (!analogEn_r) begin
      analogOut_r <= '0; // [R16]
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire [31:0] advMask = {32{advanced_r}};
  wire [31:0] rdMux =
    (addr == `OFS_CTRL)    ? {25'h0, analogEn_r, edgeSel_r, fixSel_r, autoCycle_r, advanced_r} :
    (addr == `OFS_NEAR)    ? advMask & 32'(signed'(nearLim_r)) :
    (addr == `OFS_FAR)     ? advMask & 32'(signed'(farLim_r)) :
    (addr == `OFS_MINCHG)  ? advMask & 32'(signed'(minChg_r)) :
    (addr == `OFS_MAXCHG)  ? advMask & 32'(signed'(maxChg_r)) :
    (addr == `OFS_HYST)    ? advMask & 32'(hyst_r) :
    (addr == `OFS_LAG)     ? advMask & 32'(lag_r) :
    (addr == `OFS_EDGECFG) ? advMask & {30'h0, dir_r} :
    (addr == `OFS_OFFSET)  ? 32'(signed'(offset_r)) :
    (addr == `OFS_LVLLIM)  ? {16'h0, levelLim_r} :
    (addr == `OFS_STATUS)  ? {25'h0, curSel, enough, noMeas_r, inWin_r, switchOut_r} :
    (addr == `OFS_REL)     ? 32'(signed'(relDist_r)) :
    (addr == `OFS_ABS)     ? 32'(absD_r) :
    (addr == `OFS_ANALOG)  ? 32'(signed'(analogOut_r)) :
    (addr == `OFS_LEVEL)   ? {16'h0, lvl_r} : 32'h0;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdData_r <= 32'h0;
    end else begin
      rdData_r <= rdEn ? rdMux : 32'h0;
    end
  end

  assign rdData    = rdData_r;
  assign measTrig  = measTrig_r;
  assign switchOut = switchOut_r;
  assign relDist   = relDist_r;
  assign absDist   = absD_r;
  assign analogOut = analogOut_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence seqSample;
    measTrig_r ##1 smpV_r;
  endsequence

  sequence seqAnalogOff;
    !analogEn_r ##1 !analogEn_r;
  endsequence

  a_window_blank: assert property (smpV_r && !inWin |=> $stable(switchOut_r)) // [R01]
    else $error("blanked sample changed the switching output");
  a_limit_round: assert property (wrNear |=> (nearLim_r % `MM_STEPS) == 0) // [R03]
    else $error("near limit not on a millimetre step");
  a_reset_limits: assert property ($past(!rstn) |-> nearLim_r == `PHYS_NEAR && farLim_r == `PHYS_FAR) // [R04]
    else $error("window limits not at physical range after reset");
  a_edge_drive: assert property (seqSample ##0 (sampOk && hit && edgeSel_r) |=> switchOut_r) // [R05]
    else $error("qualifying change did not drive the output");
  a_band_reject: assert property (smpV_r && sampOk && mag > hiBound |=> !edgeState_r) // [R06]
    else $error("change above the maximum was accepted");
  a_hyst_hold: assert property (smpV_r && sampOk && edgeState_r && enough && dirOk &&
                                mag >= loBound && mag < ext(minChg_r) |=> edgeState_r) // [R08]
    else $error("hysteresis did not hold the output on");
  a_dir_pos: assert property (smpV_r && sampOk && dir_r == distance_edge_pkg::DIR_POS &&
                              diff <= 0 |=> !edgeState_r) // [R09]
    else $error("positive direction accepted a falling change");
  a_trig_space: assert property (measTrig_r |=> !measTrig_r [*8]) // [R12]
    else $error("measurements closer than one cycle interval");
  a_no_meas: assert property (smpV_r && levelLow |-> !push) // [R14]
    else $error("impossible measurement entered the history");
  a_rel_offset: assert property (smpV_r |=> relDist_r == $past(relNow) && absD_r == $past(absD_r)) // [R15]
    else $error("relative distance not offset from absolute");
  a_analog_off: assert property (seqAnalogOff |-> analogOut_r == '0) // [R16]
    else $error("analog value shown while disabled");
  a_easy_lock: assert property (wrEn && !advanced_r && addr == `OFS_MINCHG |=> $stable(minChg_r)) // [R17]
    else $error("hidden setting written at easy level");
  a_once_per: assert property (seqSample |=> $past(push) == $past(sampOk) ##1 !smpV_r) // [R18]
    else $error("history not updated once per cycle");
endmodule

// [switch_reader.sv]
`timescale 1ns/1ps
// ************************************************************
// Control system that watches the switching output
// ************************************************************
module switch_reader (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic switchOut,
  output int        riseCount
);
  logic last_r;

  // It only listens, so it can never disturb the sensor it counts.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      last_r    <= 1'b0;
      riseCount <= 0;
    end else begin
      last_r <= switchOut;
      if (switchOut && !last_r) begin
        riseCount <= riseCount + 1;
      end
    end
  end
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`include "distance_edge_params.svh"
module testbench;
  localparam logic [15:0] LVL_OK  = 16'h0180;
  localparam logic [15:0] LVL_LOW = 16'h0010;
  localparam int          LIMIT   = 12000;

  logic               mclk = 1'b0;
  logic               rstn = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wrData = 32'h0;
  logic               wrEn = 1'b0;
  logic               rdEn = 1'b0;
  logic [31:0]        rdData;
  logic [`DIST_W-1:0] distIn = 20'h0;
  logic [15:0]        levelIn = 16'h0;
  logic               measTrig;
  logic               switchOut;
  logic [`DIST_W-1:0] relDist;
  logic [`DIST_W-1:0] absDist;
  logic [`DIST_W-1:0] analogOut;
  int                 riseCount;
  int                 mismatches = 0;
  int                 comparisons = 0;
  int                 cycles = 0;

  always #4 mclk = ~mclk;

  distance_edge_change_eval #(.CYC_T0(20), .CYC_T1(30), .CYC_T2(40), .CYC_T3(50), .CYC_T4(60)) uut (
    .mclk(mclk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .distIn(distIn), .levelIn(levelIn), .measTrig(measTrig), .switchOut(switchOut), .relDist(relDist),
    .absDist(absDist), .analogOut(analogOut));

  switch_reader reader (.mclk(mclk), .rstn(rstn), .switchOut(switchOut), .riseCount(riseCount));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge mclk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge mclk);
    rdEn <= 1'b0;
    #1 d = rdData;
  endtask

  task automatic rdCheck(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(name, d, exp);
  endtask

  // Outputs settle two edges after the measurement pulse; three leaves margin.
  task automatic samp(input logic [19:0] d, input logic [15:0] lvl);
    @(posedge mclk);
    distIn  <= d;
    levelIn <= lvl;
    do begin
      @(posedge mclk);
      #1;
    end while (measTrig !== 1'b1);
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // With a lag of four, five equal samples leave a zero difference.
  task automatic settle(input logic [19:0] d);
    repeat (5) samp(d, LVL_OK);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    logic [7:0]  a[6] = '{`OFS_NEAR, `OFS_FAR, `OFS_MINCHG, `OFS_MAXCHG, `OFS_HYST, `OFS_LAG};
    logic [31:0] e[6] = '{32'h000007D0, 32'h00002710, 32'h00000064, 32'h000003E8, 32'h00000005, 32'h00000008};
    rdCheck("hidden near", `OFS_NEAR, 32'h0);
    rdCheck("ctrl reset", `OFS_CTRL, 32'h00000002);
    wr(`OFS_NEAR, 32'h00000BB8);
    wr(`OFS_CTRL, 32'h00000003);
    for (int i = 0; i < 6; i++) begin
      rdCheck("setting reset", a[i], e[i]);
    end
    wr(`OFS_NEAR, 32'h000007D4);
    rdCheck("near round down", `OFS_NEAR, 32'h000007D0);
    wr(`OFS_NEAR, 32'h000007D5);
    rdCheck("near round up", `OFS_NEAR, 32'h000007DA);
    wr(`OFS_NEAR, `PHYS_NEAR);
    wr(`OFS_LAG, 32'h0000012C);
    rdCheck("lag top", `OFS_LAG, 32'h00000100);
    wr(`OFS_LAG, 32'h00000000);
    rdCheck("lag bottom", `OFS_LAG, 32'h00000001);
    rdCheck("unmapped", 8'h3C, 32'h0);
  endtask

  task automatic t_config();
    int n;
    wr(`OFS_CTRL, 32'h00000061);
    wr(`OFS_LAG, 32'h00000004);
    samp(20'h01388, LVL_OK);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n = n + 1;
    end while (measTrig !== 1'b1);
    // The sample task already used three edges after the pulse.
    check("trig spacing", n + 3, 20);
  endtask

  task automatic t_change();
    int r0;
    settle(20'h01388);
    r0 = riseCount;
    samp(20'h0157C, LVL_OK);
    check("switch on", switchOut, 1);
    check("one activation", riseCount - r0, 1);
    check("absolute", absDist, 32'h0157C);
    check("analog", analogOut, 32'h0157C - `PHYS_NEAR);
    settle(20'h0157C);
    check("switch off", switchOut, 0);
    samp(20'h01B58, LVL_OK);
    check("too large", switchOut, 0);
    settle(20'h01F40);
    samp(20'h02134, LVL_OK);
    check("far baseline", switchOut, 1);
  endtask

  task automatic t_hyst();
    settle(20'h01388);
    samp(20'h01770, LVL_OK);
    check("max inclusive", switchOut, 1);
    samp(20'h01773, LVL_OK);
    check("held by band", switchOut, 1);
    settle(20'h01388);
    samp(20'h01773, LVL_OK);
    check("not switched on", switchOut, 0);
  endtask

  task automatic t_dir();
    logic e[3] = '{1'b1, 1'b0, 1'b1};
    for (int d = 0; d < 3; d++) begin
      wr(`OFS_EDGECFG, d);
      settle(20'h01388);
      samp(20'h01194, LVL_OK);
      check("direction", switchOut, e[d]);
    end
    wr(`OFS_EDGECFG, 32'h0);
  endtask

  task automatic t_window();
    logic [31:0] s;
    wr(`OFS_NEAR, 32'h000011F8);
    settle(20'h01388);
    samp(20'h01130, LVL_OK);
    check("blanked", switchOut, 0);
    check("relative", relDist, 20'h01130 + `OFFSET_RST);
    rd(`OFS_STATUS, s);
    check("in window flag", s[1], 0);
    wr(`OFS_NEAR, `PHYS_NEAR);
  endtask

  task automatic t_level();
    logic [31:0] s;
    settle(20'h01388);
    samp(20'h0157C, LVL_LOW);
    check("weak signal", switchOut, 0);
    rd(`OFS_STATUS, s);
    check("low flag", s[2], 1);
    wr(`OFS_CTRL, 32'h00000023);
    // The automatic selection may have climbed while weak; strong samples bring it back to the fastest.
    repeat (4) samp(20'h01388, 16'h0400);
    rd(`OFS_STATUS, s);
    check("auto faster", s[6:4], 0);
    samp(20'h01388, LVL_LOW);
    rd(`OFS_STATUS, s);
    check("auto slower", s[6:4], 1);
    check("analog off", analogOut, 0);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_config();
    t_change();
    t_hyst();
    t_dir();
    t_window();
    t_level();
    finish_test();
  end
endmodule
